// File: include/uart_cfg_pkg.sv
// package: register map, field layout and state of the serial port config
package uart_cfg_pkg;
    localparam logic [7:0] OFS_BDH = 8'h00;
    localparam logic [7:0] OFS_BDL = 8'h04;
    localparam logic [7:0] OFS_LCTL = 8'h08;
    localparam logic [7:0] OFS_PCTL = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam int BIT_BRK_IE = 7;
    localparam int BIT_EDGE_IE = 6;
    localparam int BIT_LOOP = 7;
    localparam int BIT_WSTOP = 6;
    localparam int BIT_RECEIVER_SOURCE_SELECT = 5;
    localparam int BIT_NINE = 4;
    localparam int BIT_WAKE = 3;
    localparam int BIT_ILT = 2;
    localparam int BIT_PE = 1;
    localparam int BIT_PT = 0;
    localparam int BIT_TE = 3;
    localparam int BIT_RE = 2;
    localparam logic [7:0] RST_BDH = 8'h00;
    localparam logic [7:0] RST_BDL = 8'h04;
    localparam logic [7:0] RST_LCTL = 8'h00;
    localparam logic [7:0] RST_PCTL = 8'h00;
    localparam logic [7:0] BDH_WMASK = 8'hdf;
    localparam logic [7:0] PCTL_WMASK = 8'h0c;
    localparam logic [3:0] FRAME_BITS_8 = 4'ha;
    localparam logic [3:0] FRAME_BITS_9 = 4'hb;

    typedef struct packed {
        logic nine_bit;
        logic wake_addr_mark;
        logic idle_after_stop;
        logic parity_enable;
        logic parity_type;
        logic [3:0] frame_bits;
    } frame_cfg_t;

    typedef struct packed {
        logic [7:0] bdh;
        logic [12:0] div;
        logic [7:0] lctl;
        logic [7:0] pctl;
        logic started;
        logic [12:0] cnt;
        logic tick;
        logic ack;
        logic [7:0] rdat;
        logic [1:0] rxd_sync;
        logic [1:0] txd_sync;
        logic rx_ser;
        logic txd_out;
        logic tx_par;
        logic rx_perr;
    } state_t;
endpackage

// File: logic/uart_baud_and_frame_config.sv
// serial port baud generator, frame configuration and pin routing
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module uart_baud_and_frame_config
    import uart_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // event flags and cpu wait
    input wire logic break_detect_flag_i,
    input wire logic rx_edge_flag_i,
    input wire logic wait_i,
    output logic break_irq_o,
    output logic rx_edge_irq_o,
    output logic serial_clk_en_o,
    // baud tick and frame setup
    output logic baud16_tick_o,
    output frame_cfg_t frame_cfg_o,
    output logic tx_enable_o,
    output logic rx_enable_o,
    // parity
    input wire logic [8:0] tx_char_i,
    input wire logic [8:0] rx_char_i,
    output logic tx_parity_o,
    output logic rx_parity_err_o,
    // serial routing
    input wire logic tx_serial_i,
    output logic rx_serial_o,
    // pins
    input wire logic rxd_pin_i,
    output logic rxd_pin_released_o,
    input wire logic txd_pin_i,
    output logic txd_pin_o,
    output logic txd_pin_oe_o
);

    state_t s;
    state_t next_s;

    logic access;
    logic wr_go;
    logic lane0;
    logic loop_on;
    logic single_wire;
    logic frozen;
    logic running;
    logic [12:0] div_last;
    logic [12:0] next_div;
    logic [7:0] rd_mux;
    logic tx_par_calc;
    logic rx_ones;

    assign access = cyc_i && stb_i;
    // writes land at the edge where the master sees ack
    assign wr_go = access && we_i && s.ack;
    assign lane0 = sel_i[0];
    assign loop_on = s.lctl[BIT_LOOP];
    // source select only matters inside loop mode
    assign single_wire = loop_on && s.lctl[BIT_RECEIVER_SOURCE_SELECT];
    assign frozen = wait_i && s.lctl[BIT_WSTOP];
    // generator runs only once started, nonzero and not frozen
    assign running = s.started
        && (s.div != 13'h0)
        && !frozen;
    assign div_last = s.div - 13'h1;

    always_comb
    begin
        unique case (adr_i)
            OFS_BDH: rd_mux = s.bdh;
            OFS_BDL: rd_mux = s.div[7:0];
            OFS_LCTL: rd_mux = s.lctl;
            OFS_PCTL: rd_mux = s.pctl;
            OFS_STAT: rd_mux = {4'h0, single_wire, loop_on,
                s.started, running};
            default: rd_mux = 8'h00;
        endcase
    end

    // parity bit sits in the msb of the character
    always_comb
    begin
        if (s.lctl[BIT_NINE])
        begin
            tx_par_calc = (^tx_char_i[7:0]) ^ s.lctl[BIT_PT];
            rx_ones = ^rx_char_i[8:0];
        end
        else
        begin
            tx_par_calc = (^tx_char_i[6:0]) ^ s.lctl[BIT_PT];
            rx_ones = ^rx_char_i[7:0];
        end
    end

    always_comb
    begin
        next_s = s;
        next_div = s.div;
        next_s.ack = access && !s.ack;
        if (access && !s.ack)
        begin
            next_s.rdat = we_i ? 8'h00 : rd_mux;
        end
        if (wr_go && lane0)
        begin
            unique case (adr_i)
                OFS_BDH:
                begin
                    // upper divisor bits wait in the buffer
                    next_s.bdh = dat_i[7:0] & BDH_WMASK;
                end
                OFS_BDL:
                begin
                    next_div = {s.bdh[4:0], dat_i[7:0]};
                end
                OFS_LCTL:
                begin
                    next_s.lctl = dat_i[7:0];
                end
                OFS_PCTL:
                begin
                    next_s.pctl = dat_i[7:0] & PCTL_WMASK;
                    if (dat_i[BIT_TE] || dat_i[BIT_RE])
                    begin
                        next_s.started = 1'b1;
                    end
                end
                default:
                begin
                    next_s.rdat = s.rdat;
                end
            endcase
        end
        next_s.div = next_div;
        // divisor change restarts the count so no long wrap occurs
        next_s.tick = 1'b0;
        if (!running || (next_div != s.div))
        begin
            next_s.cnt = 13'h0;
        end
        else if (s.cnt >= div_last)
        begin
            next_s.cnt = 13'h0;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.cnt = s.cnt + 13'h1;
        end
        next_s.rxd_sync = {s.rxd_sync[0], rxd_pin_i};
        next_s.txd_sync = {s.txd_sync[0], txd_pin_i};
        if (!loop_on)
        begin
            next_s.rx_ser = s.rxd_sync[1];
        end
        else if (single_wire)
        begin
            next_s.rx_ser = s.txd_sync[1];
        end
        else
        begin
            next_s.rx_ser = tx_serial_i;
        end
        // idle line high while transmitter is off
        next_s.txd_out = s.pctl[BIT_TE] ? tx_serial_i : 1'b1;
        next_s.tx_par = s.lctl[BIT_PE] ? tx_par_calc : 1'b0;
        next_s.rx_perr = s.lctl[BIT_PE]
            && (rx_ones != s.lctl[BIT_PT]);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.bdh <= RST_BDH;
            s.div <= {5'h00, RST_BDL};
            s.lctl <= RST_LCTL;
            s.pctl <= RST_PCTL;
            s.rxd_sync <= 2'h3;
            s.txd_sync <= 2'h3;
            s.rx_ser <= 1'b1;
            s.txd_out <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign ack_o = s.ack;
    assign dat_o = {24'h000000, s.rdat};
    assign break_irq_o = s.bdh[BIT_BRK_IE] && break_detect_flag_i;
    assign rx_edge_irq_o = s.bdh[BIT_EDGE_IE] && rx_edge_flag_i;
    assign serial_clk_en_o = !frozen;
    assign baud16_tick_o = s.tick;
    assign frame_cfg_o.nine_bit = s.lctl[BIT_NINE];
    assign frame_cfg_o.wake_addr_mark = s.lctl[BIT_WAKE];
    assign frame_cfg_o.idle_after_stop = s.lctl[BIT_ILT];
    assign frame_cfg_o.parity_enable = s.lctl[BIT_PE];
    assign frame_cfg_o.parity_type = s.lctl[BIT_PT];
    assign frame_cfg_o.frame_bits = s.lctl[BIT_NINE] ? FRAME_BITS_9
        : FRAME_BITS_8;
    assign tx_enable_o = s.pctl[BIT_TE];
    assign rx_enable_o = s.pctl[BIT_RE];
    assign tx_parity_o = s.tx_par;
    assign rx_parity_err_o = s.rx_perr;
    assign rx_serial_o = s.rx_ser;
    assign rxd_pin_released_o = !s.pctl[BIT_RE] || loop_on;
    assign txd_pin_o = s.txd_out;
    assign txd_pin_oe_o = s.pctl[BIT_TE];

    // checking helpers: cycles between ticks with a steady divisor
    logic [12:0] h_gap;
    logic h_ok;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !running || (next_s.div != s.div))
        begin
            h_gap <= 13'h0;
            h_ok <= 1'b0;
        end
        else if (s.tick)
        begin
            h_gap <= 13'h1;
            h_ok <= 1'b1;
        end
        else
        begin
            h_gap <= h_gap + 13'h1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_TICK_PERIOD: assert property (
        s.tick && h_ok |-> h_gap == s.div)
        else $error("baud tick spacing differs from divisor");

    AST_ZERO_STOPS: assert property (
        s.div == 13'h0 |=> !s.tick [*3])
        else $error("tick seen with zero divisor");

    AST_NOT_STARTED: assert property (
        !s.started |=> !s.tick)
        else $error("tick before any enable written");

    AST_DIV_BUFFERED: assert property (
        !(wr_go && lane0 && adr_i == OFS_BDL) |=> $stable(s.div))
        else $error("divisor changed without low byte write");

    AST_DIV_APPLY: assert property (
        wr_go && lane0 && adr_i == OFS_BDL
        |=> s.div == {$past(s.bdh[4:0]), $past(dat_i[7:0])})
        else $error("low byte write did not apply divisor");

    AST_IRQ_GATE: assert property (
        !s.bdh[BIT_BRK_IE] || !break_detect_flag_i |-> !break_irq_o)
        else $error("break request while disabled");

    AST_EDGE_GATE: assert property (
        rx_edge_flag_i && s.bdh[BIT_EDGE_IE] |-> rx_edge_irq_o)
        else $error("edge request missing");

    AST_LOOPBACK: assert property (
        loop_on && !s.lctl[BIT_RECEIVER_SOURCE_SELECT]
        |=> rx_serial_o == $past(tx_serial_i))
        else $error("loopback not routed");

    AST_SINGLE_WIRE: assert property (
        single_wire |=> rx_serial_o == $past(s.txd_sync[1]))
        else $error("single wire not routed");

    AST_NORMAL_PIN: assert property (
        !loop_on |=> rx_serial_o == $past(s.rxd_sync[1]))
        else $error("receive pin not routed");

    AST_WAIT_FREEZE: assert property (
        frozen |=> !s.tick && s.cnt == 13'h0)
        else $error("clocks ran while frozen");

    AST_TX_DRIVE: assert property (
        !txd_pin_oe_o |=> txd_pin_o)
        else $error("transmit pin active while disabled");

    AST_RX_RELEASE: assert property (
        loop_on |-> rxd_pin_released_o)
        else $error("receive pin held in loop mode");

    AST_NO_PARITY: assert property (
        !s.lctl[BIT_PE] |=> !rx_parity_err_o && !tx_parity_o)
        else $error("parity active while disabled");

    AST_FRAME_LEN: assert property (
        frame_cfg_o.nine_bit |-> frame_cfg_o.frame_bits == 4'hb)
        else $error("nine bit frame length wrong");

    AST_ACK_DROP: assert property (
        s.ack |=> !s.ack)
        else $error("ack held two cycles");

    COV_TICKS: cover property (
        s.tick ##[1:40] s.tick);

    COV_SINGLE_WIRE: cover property (
        single_wire && s.pctl[BIT_TE] && s.tick);

    COV_FREEZE: cover property (
        running ##1 frozen);

endmodule

// File: test/remote_node.sv
// remote serial node: drives the receive pin and the shared single wire
`timescale 1ns/10ps
module remote_node (
    // bus clock
    input wire logic clk_i,
    // port side of the shared wire
    input wire logic txd_pin_i,
    input wire logic txd_oe_i,
    // line levels seen by the port
    output logic rxd_o,
    output logic wire_o
);
    logic drv = 1'b1;
    initial rxd_o = 1'b1;
    // the wire shows our level only while the port has let go of it
    assign wire_o = txd_oe_i ? txd_pin_i : drv;
    task automatic put(input logic rx, input logic w);
        @(posedge clk_i);
        rxd_o <= rx;
        drv <= w;
    endtask
endmodule

// File: test/uart_baud_and_frame_config_tb.sv
// self-checking bench for the serial port configuration block
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module uart_baud_and_frame_config_tb;
    import uart_cfg_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] dat = '0, dat_o, rexp;
    logic ack_o, brk = 1'b0, edg = 1'b0, wt = 1'b0;
    logic brk_irq, edg_irq, clk_en, tick;
    frame_cfg_t fc;
    logic te_o, re_o, txs = 1'b1, txp, perr, rxs, rel, txd, oe, rxd, wl;
    logic [8:0] txc = '0, rxc = '0;
    logic [7:0] v, r;
    logic [31:0] rq[$];
    int err_count = 0, compares = 0, seed = 32'hbe0d, ticks = 0, m, n;

    always #25 clk_i = ~clk_i;

    uart_baud_and_frame_config DUT (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .break_detect_flag_i(brk), .rx_edge_flag_i(edg), .wait_i(wt),
        .break_irq_o(brk_irq), .rx_edge_irq_o(edg_irq),
        .serial_clk_en_o(clk_en), .baud16_tick_o(tick), .frame_cfg_o(fc),
        .tx_enable_o(te_o), .rx_enable_o(re_o), .tx_char_i(txc),
        .rx_char_i(rxc), .tx_parity_o(txp), .rx_parity_err_o(perr),
        .tx_serial_i(txs), .rx_serial_o(rxs), .rxd_pin_i(rxd),
        .rxd_pin_released_o(rel), .txd_pin_i(wl), .txd_pin_o(txd),
        .txd_pin_oe_o(oe));

    remote_node nd (.clk_i(clk_i), .txd_pin_i(txd), .txd_oe_i(oe),
        .rxd_o(rxd), .wire_o(wl));

    // read data is checked against the oldest noted value at its ack
    always @(posedge clk_i)
    begin
        if (tick === 1'b1)
            ticks <= ticks + 1;
        if (ack_o === 1'b1 && we === 1'b0)
        begin
            rexp = rq.pop_front();
            `CHK(dat_o, rexp)
        end
    end

    task automatic conclude();
        $display("counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= {24'h000000, d};
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk_i);
            if (ack_o === 1'b1)
                break;
        end
        if (k == 50)
            err_count++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back({24'h000000, e});
        wb(1'b0, a, 8'h00);
    endtask

    // cycles between two ticks must equal the divisor
    task automatic per(input int e);
        int c;
        for (c = 0; c < 400; c++)
        begin
            @(posedge clk_i);
            if (tick === 1'b1)
                break;
        end
        for (c = 1; c < 400; c++)
        begin
            @(posedge clk_i);
            if (tick === 1'b1)
                break;
        end
        `CHK(c, e)
    endtask

    task automatic quiet();
        int t0;
        t0 = ticks;
        repeat (40) @(posedge clk_i);
        `CHK(ticks - t0, 0)
    endtask

    initial
    begin
        #2000000;
        err_count++;
        conclude();
    end

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_BDH, RST_BDH);
        rd(OFS_BDL, RST_BDL);
        rd(OFS_LCTL, RST_LCTL);
        rd(8'h14, 8'h00);
        `CHK({txd, oe, rel}, 3'b101)
        wb(1'b1, OFS_BDL, 8'h03);
        quiet();
        $display("test reset done");
        wb(1'b1, OFS_PCTL, 8'h08);
        per(3);
        // bit 5 is not writable and must read back as zero
        wb(1'b1, OFS_BDH, 8'he1);
        per(3);
        rd(OFS_BDH, 8'hc1);
        wb(1'b1, OFS_BDL, 8'h00);
        per(256);
        wb(1'b1, OFS_BDH, 8'hc0);
        wb(1'b1, OFS_BDL, 8'h00);
        quiet();
        wb(1'b1, OFS_BDL, 8'h05);
        per(5);
        rd(OFS_STAT, 8'h03);
        $display("test baud done");
        for (n = 0; n < 6; n++)
        begin
            v = 8'($random(seed));
            wb(1'b1, OFS_BDH, v & 8'hc0);
            brk <= v[0];
            edg <= v[1];
            @(posedge clk_i);
            @(posedge clk_i);
            `CHK(brk_irq, v[0] & v[7])
            `CHK(edg_irq, v[1] & v[6])
        end
        $display("test irq enables done");
        for (n = 0; n < 12; n++)
        begin
            v = 8'($random(seed));
            txc <= 9'($random(seed));
            rxc <= 9'($random(seed));
            wt <= v[5];
            wb(1'b1, OFS_LCTL, v);
            // parity outputs follow the new line control one edge later
            repeat (2) @(posedge clk_i);
            `CHK(fc.nine_bit, v[4])
            `CHK(fc.frame_bits, v[4] ? FRAME_BITS_9 : FRAME_BITS_8)
            `CHK(fc.wake_addr_mark, v[3])
            `CHK(fc.idle_after_stop, v[2])
            `CHK({fc.parity_enable, fc.parity_type}, v[1:0])
            `CHK(txp, v[1] & (v[0] ^ (v[4] ? ^txc[7:0] : ^txc[6:0])))
            `CHK(perr, v[1] & (v[0] ^ (v[4] ? ^rxc : ^rxc[7:0])))
            `CHK(clk_en, ~(v[5] & v[6]))
        end
        $display("test frame setup done");
        wb(1'b1, OFS_PCTL, 8'h04);
        @(posedge clk_i);
        `CHK({te_o, re_o}, 2'b01)
        for (m = 0; m < 3; m++)
            for (n = 0; n < 4; n++)
            begin
                r = 8'($random(seed));
                wb(1'b1, OFS_LCTL, m == 0 ? {2'b00, r[3], 5'h00} :
                    (m == 1 ? 8'h80 : 8'ha0));
                nd.put(r[0], r[2]);
                txs <= r[1];
                repeat (4) @(posedge clk_i);
                `CHK(rxs, r[m])
                `CHK(rel, m != 0)
            end
        wb(1'b1, OFS_PCTL, 8'h08);
        for (n = 0; n < 4; n++)
        begin
            r = 8'($random(seed));
            txs <= r[0];
            repeat (3) @(posedge clk_i);
            `CHK({txd, oe, rel}, {r[0], 2'b11})
            `CHK({te_o, re_o}, 2'b10)
        end
        $display("test routing done");
        conclude();
    end
endmodule
